//--- rtl/guard_pkg.sv
package guard_pkg;
	localparam int N_INST = 2;
	localparam int INST_W = 1;
	localparam int ADC_W = 10;
	localparam int SMP_W = 8;
	localparam int ACC_W = 14;
	localparam int FRAC_W = 6;
	localparam int DIV_W = 20;
	localparam int TMR_W = 16;
	localparam int ADDR_W = 8;
	localparam int W4_SHIFT = 2;
	localparam int W64_SHIFT = 6;
	localparam int CLK_MHZ = 48;

	// register map
	localparam int INST_SEL_BIT = 5;
	localparam int WRD_LSB = 2;
	localparam int WRD_W = 3;
	localparam logic [WRD_W-1:0] WRD_CTRL = 3'h0;
	localparam logic [WRD_W-1:0] WRD_DATA = 3'h1;
	localparam logic [WRD_W-1:0] WRD_REF = 3'h2;
	localparam logic [WRD_W-1:0] WRD_TMR = 3'h3;
	localparam logic [WRD_W-1:0] WRD_LPF1 = 3'h4;
	localparam logic [WRD_W-1:0] WRD_LPF2 = 3'h5;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h40;
	localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 8'h44;
	localparam logic [ADDR_W-1:0] WORD_MASK = 8'hFC;

	// field positions
	localparam int CTRL_DIS = 0;
	localparam int CTRL_TEST = 1;
	localparam int CTRL_DSEL_LSB = 2;
	localparam int CTRL_HI_ST = 8;
	localparam int CTRL_LO_ST = 9;
	localparam int CTRL_THR_ST = 10;
	localparam int CTRL_PIN_ST = 11;
	localparam int DATA_TEST_LSB = 0;
	localparam int DATA_SMP_LSB = 8;
	localparam int DATA_F1_LSB = 16;
	localparam int DATA_F2_LSB = 24;
	localparam int REF_LO_LSB = 0;
	localparam int REF_HI_LSB = 8;
	localparam int TMR_HI_LSB = 0;
	localparam int TMR_LO_LSB = 16;
	localparam int LPF_DIV_LSB = 0;
	localparam int LPF_W4_BIT = 24;
	localparam int CMP_HI = 0;
	localparam int CMP_LO = 1;
	localparam int IRQ_FORCE = 0;
	localparam int IRQ_INST_BASE = 1;
	localparam int IRQ_PER_INST = 4;
	localparam int IRQ_W = IRQ_INST_BASE + N_INST * IRQ_PER_INST;

	// reset values and write masks
	localparam logic [31:0] CTRL_RST = 32'h0000_0001;
	localparam logic [31:0] CTRL_WMASK = 32'h0000_000F;
	localparam logic [31:0] DATA_RST = 32'h0000_0000;
	localparam logic [31:0] DATA_WMASK = 32'h0000_00FF;
	localparam logic [31:0] REF_RST = 32'h0000_FF00;
	localparam logic [31:0] REF_WMASK = 32'h0000_FFFF;
	localparam logic [31:0] TMR_RST = 32'h0000_0000;
	localparam logic [31:0] LPF_RST = 32'h0000_0000;
	localparam logic [31:0] LPF_WMASK = 32'h010F_FFFF;
	localparam logic [IRQ_W-1:0] IRQ_EN_RST = 9'h000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {DSEL_RAW, DSEL_LPF1, DSEL_LPF2} data_sel_t;

	typedef struct packed {
		logic [DIV_W-1:0] div;
		logic w4;
	} lpf_cfg_t;

	typedef struct packed {
		logic ok;
		logic inst_hit;
		logic [INST_W-1:0] inst;
		logic [WRD_W-1:0] word;
		logic stat;
		logic en;
	} dec_t;

	function automatic dec_t decode(input logic [ADDR_W-1:0] a);
		dec_t d;
		logic [ADDR_W-1:0] w;
		d = '0;
		w = a & WORD_MASK;
		if (w < OFS_IRQ_STAT) begin
			d.inst_hit = 1'b1;
			d.inst = a[INST_SEL_BIT];
			d.word = a[WRD_LSB +: WRD_W];
			d.ok = (d.word <= WRD_LPF2);
		end else if (w == OFS_IRQ_STAT) begin
			d.stat = 1'b1;
			d.ok = 1'b1;
		end else if (w == OFS_IRQ_EN) begin
			d.en = 1'b1;
			d.ok = 1'b1;
		end
		return d;
	endfunction

	function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return r;
	endfunction
endpackage

//--- rtl/lpf_stage.sv
`timescale 1ns/10ps
module lpf_stage (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic run,
	input wire guard_pkg::lpf_cfg_t cfg,
	input wire logic [guard_pkg::SMP_W-1:0] sample,
	output logic [guard_pkg::SMP_W-1:0] avg
);
	logic [guard_pkg::DIV_W-1:0] div_q;
	logic [guard_pkg::ACC_W-1:0] acc_q;
	logic [guard_pkg::ACC_W-1:0] leak;
	logic [guard_pkg::ACC_W-1:0] feed;
	logic [guard_pkg::ACC_W-1:0] scaled;
	logic tick;

	// sample strobe at clock / (divider + 1); zero means every cycle
	assign tick = (div_q >= cfg.div);
	always_ff @(posedge aclk) begin
		if (!aresetn || !run) begin
			div_q <= '0;
		end else if (tick) begin
			div_q <= '0;
		end else begin
			div_q <= guard_pkg::DIV_W'(div_q + 1'b1);
		end
	end

	// avg += (sample - avg) / W in 8.6 fixed point; cannot overflow
	assign scaled = {sample, {guard_pkg::FRAC_W{1'b0}}};
	assign leak = cfg.w4 ? (acc_q >> guard_pkg::W4_SHIFT) : (acc_q >> guard_pkg::W64_SHIFT);
	assign feed = cfg.w4 ? (scaled >> guard_pkg::W4_SHIFT) : (scaled >> guard_pkg::W64_SHIFT);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acc_q <= '0;
		end else if (run && tick) begin
			acc_q <= guard_pkg::ACC_W'(acc_q - leak + feed);
		end
	end

	assign avg = acc_q[guard_pkg::ACC_W-1:guard_pkg::FRAC_W];
endmodule

//--- rtl/supply_voltage_guard.sv
// Contract
// - throttle line is active low, pulled low whenever any contribution asks.
// - override_in low forces the throttle line low in bidirectional pin mode, regardless of the other inputs.
// - instance 0 reads converter channel 0, instance 1 reads channel 1.
// - pwm force input is a throttle contribution, allowing square-wave throttling.
// - everything runs on one clock.
// - system reset returns every register and all state to defaults.
// - guard_irq is any of nine status bits anded with its enable.
// - an instance sits idle in low power while its disable bit is set.
// - per-instance throttles are ored into one pin throttle.
// - throttle reaches the pin only in bidirectional pin mode.
// - front end of each instance picks the sample source.
// - samples pass a two-stage low-pass, then a data select, then comparators.
// - each comparator output is delayed by a timer before the or logic.
// - or logic merges delayed compares, pwm force, duty flag and override.
// - high compare is input >= high ref; low compare is input <= low ref.
// - converter samples keep their upper 8 of 10 bits; test value is 8-bit.
// - test-select bit feeds the firmware test sample instead of the converter.
// - data select offers raw samples, first stage, or full two-stage output.
`timescale 1ns/10ps
module supply_voltage_guard (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [guard_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [guard_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic [guard_pkg::N_INST-1:0][guard_pkg::ADC_W-1:0] supply_sense_in,
	input wire logic [guard_pkg::N_INST-1:0] supply_sense_valid,
	input wire logic force_throttle_n,
	input wire logic duty_limit_flag,
	input wire logic override_in,
	input wire logic pin_bidir_sel,
	input wire logic throttle_in,
	output logic throttle_out,
	output logic throttle_oe,
	output logic guard_irq
);
	// bus side state
	logic aw_got_q;
	logic w_got_q;
	logic [guard_pkg::ADDR_W-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [1:0] rresp_q;
	logic [31:0] rdata_q;
	logic wr_fire;
	logic rd_fire;
	guard_pkg::dec_t wdec;
	guard_pkg::dec_t rdec;
	logic [31:0] rd_word;

	// configuration words, one set per instance, and the shared interrupt words
	logic [guard_pkg::N_INST-1:0][31:0] ctrl_q;
	logic [guard_pkg::N_INST-1:0][31:0] data_q;
	logic [guard_pkg::N_INST-1:0][31:0] ref_q;
	logic [guard_pkg::N_INST-1:0][31:0] tmr_q;
	logic [guard_pkg::N_INST-1:0][31:0] lpf1_q;
	logic [guard_pkg::N_INST-1:0][31:0] lpf2_q;
	logic [guard_pkg::IRQ_W-1:0] irq_stat_q;
	logic [guard_pkg::IRQ_W-1:0] irq_en_q;
	logic [guard_pkg::IRQ_W-1:0] irq_set;
	logic [guard_pkg::IRQ_W-1:0] irq_clr;

	// per-instance observation, then shared throttle, pin and interrupt state
	logic [guard_pkg::N_INST-1:0][guard_pkg::SMP_W-1:0] front_all;
	logic [guard_pkg::N_INST-1:0][guard_pkg::SMP_W-1:0] f1_all;
	logic [guard_pkg::N_INST-1:0][guard_pkg::SMP_W-1:0] f2_all;
	logic [guard_pkg::N_INST-1:0][1:0] dly_all;
	logic [guard_pkg::N_INST-1:0] inst_thr;
	logic throttle_req;
	logic throttle_oe_q;
	logic pin_level_q;
	logic guard_irq_q;

	// write address and data may arrive in either order; each is held until both are in
	assign awready = !aw_got_q && !bvalid_q;
	assign wready = !w_got_q && !bvalid_q;
	assign wr_fire = aw_got_q && w_got_q && !bvalid_q;
	assign wdec = guard_pkg::decode(awaddr_q);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_q <= 1'b0;
			awaddr_q <= '0;
		end else if (awvalid && awready) begin
			aw_got_q <= 1'b1;
			awaddr_q <= awaddr;
		end else if (wr_fire) begin
			aw_got_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_got_q <= 1'b0;
			wdata_q <= '0;
			wstrb_q <= '0;
		end else if (wvalid && wready) begin
			w_got_q <= 1'b1;
			wdata_q <= wdata;
			wstrb_q <= wstrb;
		end else if (wr_fire) begin
			w_got_q <= 1'b0;
		end
	end

	// write response one cycle after both halves are held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q <= guard_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			bresp_q <= wdec.ok ? guard_pkg::RESP_OKAY : guard_pkg::RESP_SLVERR;
		end else if (bready) begin
			bvalid_q <= 1'b0;
		end
	end

	assign bvalid = bvalid_q;
	assign bresp = bresp_q;

	// configuration writes; reserved bits are masked so they read back zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < guard_pkg::N_INST; i++) begin
				ctrl_q[i] <= guard_pkg::CTRL_RST;
				data_q[i] <= guard_pkg::DATA_RST;
				ref_q[i] <= guard_pkg::REF_RST;
				tmr_q[i] <= guard_pkg::TMR_RST;
				lpf1_q[i] <= guard_pkg::LPF_RST;
				lpf2_q[i] <= guard_pkg::LPF_RST;
			end
		end else if (wr_fire && wdec.ok && wdec.inst_hit) begin
			unique case (wdec.word)
				guard_pkg::WRD_CTRL: begin
					ctrl_q[wdec.inst] <= guard_pkg::strb_merge(ctrl_q[wdec.inst], wdata_q, wstrb_q)
						& guard_pkg::CTRL_WMASK;
				end
				guard_pkg::WRD_DATA: begin
					data_q[wdec.inst] <= guard_pkg::strb_merge(data_q[wdec.inst], wdata_q, wstrb_q)
						& guard_pkg::DATA_WMASK;
				end
				guard_pkg::WRD_REF: begin
					ref_q[wdec.inst] <= guard_pkg::strb_merge(ref_q[wdec.inst], wdata_q, wstrb_q)
						& guard_pkg::REF_WMASK;
				end
				guard_pkg::WRD_TMR: begin
					tmr_q[wdec.inst] <= guard_pkg::strb_merge(tmr_q[wdec.inst], wdata_q, wstrb_q);
				end
				guard_pkg::WRD_LPF1: begin
					lpf1_q[wdec.inst] <= guard_pkg::strb_merge(lpf1_q[wdec.inst], wdata_q, wstrb_q)
						& guard_pkg::LPF_WMASK;
				end
				guard_pkg::WRD_LPF2: begin
					lpf2_q[wdec.inst] <= guard_pkg::strb_merge(lpf2_q[wdec.inst], wdata_q, wstrb_q)
						& guard_pkg::LPF_WMASK;
				end
				default: begin
				end
			endcase
		end
	end

	// interrupt enable word
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_en_q <= guard_pkg::IRQ_EN_RST;
		end else if (wr_fire && wdec.en) begin
			irq_en_q <= guard_pkg::IRQ_W'(guard_pkg::strb_merge(32'(irq_en_q), wdata_q, wstrb_q));
		end
	end

	// sticky status, write one to clear; a new event in the clear cycle wins
	assign irq_clr = (wr_fire && wdec.stat) ?
		guard_pkg::IRQ_W'(guard_pkg::strb_merge(32'h0000_0000, wdata_q, wstrb_q)) : '0;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_q <= '0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
		end
	end

	// force status is set in every cycle the pwm level is low and stays set until cleared
	assign irq_set[guard_pkg::IRQ_FORCE] = !force_throttle_n;

	// registered so the line cannot glitch on a status write
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			guard_irq_q <= 1'b0;
		end else begin
			guard_irq_q <= |(irq_stat_q & irq_en_q);
		end
	end

	assign guard_irq = guard_irq_q;

	// one read at a time; data captured when the address is taken
	assign arready = !rvalid_q;
	assign rd_fire = arvalid && arready;
	assign rdec = guard_pkg::decode(araddr);

	always_comb begin
		rd_word = '0;
		if (rdec.inst_hit) begin
			unique case (rdec.word)
				guard_pkg::WRD_CTRL: begin
					rd_word = ctrl_q[rdec.inst];
					rd_word[guard_pkg::CTRL_HI_ST] = dly_all[rdec.inst][guard_pkg::CMP_HI];
					rd_word[guard_pkg::CTRL_LO_ST] = dly_all[rdec.inst][guard_pkg::CMP_LO];
					rd_word[guard_pkg::CTRL_THR_ST] = inst_thr[rdec.inst];
					rd_word[guard_pkg::CTRL_PIN_ST] = pin_level_q;
				end
				guard_pkg::WRD_DATA: begin
					rd_word = data_q[rdec.inst];
					rd_word[guard_pkg::DATA_SMP_LSB +: guard_pkg::SMP_W] = front_all[rdec.inst];
					rd_word[guard_pkg::DATA_F1_LSB +: guard_pkg::SMP_W] = f1_all[rdec.inst];
					rd_word[guard_pkg::DATA_F2_LSB +: guard_pkg::SMP_W] = f2_all[rdec.inst];
				end
				guard_pkg::WRD_REF: rd_word = ref_q[rdec.inst];
				guard_pkg::WRD_TMR: rd_word = tmr_q[rdec.inst];
				guard_pkg::WRD_LPF1: rd_word = lpf1_q[rdec.inst];
				guard_pkg::WRD_LPF2: rd_word = lpf2_q[rdec.inst];
				default: rd_word = '0;
			endcase
		end else if (rdec.stat) begin
			rd_word = 32'(irq_stat_q);
		end else if (rdec.en) begin
			rd_word = 32'(irq_en_q);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= guard_pkg::RESP_OKAY;
		end else if (rd_fire) begin
			rvalid_q <= 1'b1;
			rdata_q <= rd_word;
			rresp_q <= rdec.ok ? guard_pkg::RESP_OKAY : guard_pkg::RESP_SLVERR;
		end else if (rready) begin
			rvalid_q <= 1'b0;
		end
	end

	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;

	// one guard channel per converter channel, index for index
	for (genvar g = 0; g < guard_pkg::N_INST; g++) begin : g_inst
		logic run;
		logic [guard_pkg::SMP_W-1:0] adc_q;
		logic [guard_pkg::SMP_W-1:0] front;
		logic [guard_pkg::SMP_W-1:0] f1;
		logic [guard_pkg::SMP_W-1:0] f2;
		logic [guard_pkg::SMP_W-1:0] cmp_in;
		logic [guard_pkg::SMP_W-1:0] hi_ref;
		logic [guard_pkg::SMP_W-1:0] lo_ref;
		logic [1:0] raw;
		logic [1:0] dly_q;
		logic [1:0] prev_q;
		logic [1:0][guard_pkg::TMR_W-1:0] lim;
		guard_pkg::lpf_cfg_t cfg1;
		guard_pkg::lpf_cfg_t cfg2;

		// disabled instance freezes its data path and drops its throttle
		assign run = !ctrl_q[g][guard_pkg::CTRL_DIS];

		// converter reading trimmed to its upper bits
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				adc_q <= '0;
			end else if (run && supply_sense_valid[g]) begin
				adc_q <= supply_sense_in[g][guard_pkg::ADC_W-1 -: guard_pkg::SMP_W];
			end
		end

		// test value replaces converter data in the same 8-bit format
		assign front = ctrl_q[g][guard_pkg::CTRL_TEST] ?
			data_q[g][guard_pkg::DATA_TEST_LSB +: guard_pkg::SMP_W] : adc_q;

		assign cfg1.div = lpf1_q[g][guard_pkg::LPF_DIV_LSB +: guard_pkg::DIV_W];
		assign cfg1.w4 = lpf1_q[g][guard_pkg::LPF_W4_BIT];
		assign cfg2.div = lpf2_q[g][guard_pkg::LPF_DIV_LSB +: guard_pkg::DIV_W];
		assign cfg2.w4 = lpf2_q[g][guard_pkg::LPF_W4_BIT];

		// two identical first-order stages in series
		lpf_stage u_lpf1 (
			.aclk(aclk),
			.aresetn(aresetn),
			.run(run),
			.cfg(cfg1),
			.sample(front),
			.avg(f1)
		);
		lpf_stage u_lpf2 (
			.aclk(aclk),
			.aresetn(aresetn),
			.run(run),
			.cfg(cfg2),
			.sample(f1),
			.avg(f2)
		);

		// comparator source; the spare code acts as the full filter
		always_comb begin
			unique case (guard_pkg::data_sel_t'(ctrl_q[g][guard_pkg::CTRL_DSEL_LSB +: 2]))
				guard_pkg::DSEL_RAW: cmp_in = front;
				guard_pkg::DSEL_LPF1: cmp_in = f1;
				guard_pkg::DSEL_LPF2: cmp_in = f2;
				default: cmp_in = f2;
			endcase
		end

		// inclusive thresholds on both sides
		assign hi_ref = ref_q[g][guard_pkg::REF_HI_LSB +: guard_pkg::SMP_W];
		assign lo_ref = ref_q[g][guard_pkg::REF_LO_LSB +: guard_pkg::SMP_W];
		assign raw[guard_pkg::CMP_HI] = run && (cmp_in >= hi_ref);
		assign raw[guard_pkg::CMP_LO] = run && (cmp_in <= lo_ref);
		assign lim[guard_pkg::CMP_HI] = tmr_q[g][guard_pkg::TMR_HI_LSB +: guard_pkg::TMR_W];
		assign lim[guard_pkg::CMP_LO] = tmr_q[g][guard_pkg::TMR_LO_LSB +: guard_pkg::TMR_W];

		// delayed output changes once the raw compare has held its new level lim+1 cycles;
		// a bounce restarts the count, which filters glitches in both directions
		for (genvar j = 0; j < 2; j++) begin : g_tmr
			logic [guard_pkg::TMR_W-1:0] cnt_q;
			always_ff @(posedge aclk) begin
				if (!aresetn || !run) begin
					cnt_q <= '0;
					dly_q[j] <= 1'b0;
				end else if (raw[j] == dly_q[j]) begin
					cnt_q <= '0;
				end else if (cnt_q >= lim[j]) begin
					cnt_q <= '0;
					dly_q[j] <= raw[j];
				end else begin
					cnt_q <= guard_pkg::TMR_W'(cnt_q + 1'b1);
				end
			end
		end

		// previous delayed levels for edge events
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				prev_q <= '0;
			end else begin
				prev_q <= dly_q;
			end
		end

		localparam int B = guard_pkg::IRQ_INST_BASE + g * guard_pkg::IRQ_PER_INST;
		assign irq_set[B] = dly_q[guard_pkg::CMP_LO] && !prev_q[guard_pkg::CMP_LO];
		assign irq_set[B + 1] = dly_q[guard_pkg::CMP_HI] && !prev_q[guard_pkg::CMP_HI];
		assign irq_set[B + 2] = !dly_q[guard_pkg::CMP_LO] && prev_q[guard_pkg::CMP_LO];
		assign irq_set[B + 3] = !dly_q[guard_pkg::CMP_HI] && prev_q[guard_pkg::CMP_HI];

		assign front_all[g] = front;
		assign f1_all[g] = f1;
		assign f2_all[g] = f2;
		assign dly_all[g] = dly_q;
		assign inst_thr[g] = |dly_q;
	end

	// or of every contribution; override and force are active low inputs
	assign throttle_req = (|inst_thr) || !force_throttle_n || duty_limit_flag
		|| !override_in;

	// open drain: only ever pull low, and only in bidirectional pin mode
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			throttle_oe_q <= 1'b0;
			pin_level_q <= 1'b1;
		end else begin
			throttle_oe_q <= pin_bidir_sel && throttle_req;
			pin_level_q <= throttle_in;
		end
	end

	assign throttle_out = 1'b0;
	assign throttle_oe = throttle_oe_q;
endmodule

//--- verif/guard_checker.sv
`timescale 1ns/10ps
module guard_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic force_throttle_n,
	input wire logic duty_limit_flag,
	input wire logic override_in,
	input wire logic pin_bidir_sel,
	input wire logic throttle_out,
	input wire logic throttle_oe,
	input wire logic guard_irq
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// each external pull source (override, pwm force, duty flag) shows on the enable one edge later, only in bidir mode
	a_override_pulls: assert property (pin_bidir_sel && !override_in |=> throttle_oe)
		else $error("override did not pull the line");
	a_pwm_pulls: assert property (pin_bidir_sel && !force_throttle_n |=> throttle_oe)
		else $error("pwm force did not pull the line");
	a_duty_pulls: assert property (pin_bidir_sel && duty_limit_flag |=> throttle_oe)
		else $error("duty flag did not pull the line");
	a_mode_gates: assert property (!pin_bidir_sel |=> !throttle_oe)
		else $error("line pulled outside bidir mode");
	// open drain: data is always low, only the enable moves
	a_drain_low: assert property (throttle_out == 1'b0)
		else $error("throttle data not low");
	a_reset_quiet: assert property ($rose(aresetn) |-> !throttle_oe && !guard_irq && !bvalid)
		else $error("outputs not quiet after reset");
	a_bresp_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");
	a_rdata_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped early");
	a_read_answers: assert property (arvalid && arready |=> rvalid)
		else $error("read not answered in one edge");
	a_write_answers: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
		else $error("write not answered");
	c_override: cover property (pin_bidir_sel && !override_in ##1 throttle_oe);
	c_pwm: cover property ($fell(force_throttle_n) && pin_bidir_sel);
	c_irq: cover property ($rose(guard_irq));
endmodule

//--- verif/far_side_model.sv
`timescale 1ns/10ps
module far_side_model #(
	parameter int PWM_HALF = 3
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [guard_pkg::N_INST-1:0][guard_pkg::ADC_W-1:0] sample_cmd,
	input wire logic pwm_en,
	input wire logic duty_cmd,
	input wire logic throttle_oe,
	output logic [guard_pkg::N_INST-1:0][guard_pkg::ADC_W-1:0] supply_sense_in,
	output logic [guard_pkg::N_INST-1:0] supply_sense_valid,
	output logic force_throttle_n,
	output logic duty_limit_flag,
	output logic throttle_in
);
	logic [7:0] cnt_q;
	// converter serves channels in turn; between conversions the bus shows junk
	always_ff @(posedge aclk) begin
		cnt_q <= aresetn ? cnt_q + 8'h01 : 8'h00;
		for (int c = 0; c < guard_pkg::N_INST; c++) begin
			supply_sense_valid[c] <= aresetn && (cnt_q[1:0] == 2'(c));
			supply_sense_in[c] <= (cnt_q[1:0] == 2'(c)) ? sample_cmd[c] : ~sample_cmd[c];
		end
	end
	// square wave only while the pwm runs, idle high
	always_ff @(posedge aclk) begin
		if (!aresetn || !pwm_en) begin
			force_throttle_n <= 1'b1;
		end else if (cnt_q % PWM_HALF == 0) begin
			force_throttle_n <= !force_throttle_n;
		end
	end
	// monitor flag is a registered level
	always_ff @(posedge aclk) begin
		duty_limit_flag <= aresetn && duty_cmd;
	end
	// pin is open drain with a pull-up, so it reads high when released
	assign throttle_in = !throttle_oe;
endmodule

//--- verif/supply_voltage_guard_tb.sv
`timescale 1ns/10ps
`define CHK(g, e, m) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
	$display("CHECK FAILED %0t %s", $time, m); end end
module supply_voltage_guard_tb;
	logic aclk = 1'b0, aresetn = 1'b0, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, throttle_out, throttle_oe, guard_irq;
	logic [7:0] awaddr, araddr, b;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	logic [1:0][9:0] smp, sense;
	logic [1:0] sense_v;
	logic force_n, duty, duty_cmd, pwm_en, override_in, pin_bidir_sel, throttle_in, e;
	logic [9:0] s;
	int n_fail = 0, comparisons = 0;
	always #12.5 aclk = ~aclk;
	supply_voltage_guard i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .supply_sense_in(sense), .supply_sense_valid(sense_v),
		.force_throttle_n(force_n), .duty_limit_flag(duty), .override_in(override_in),
		.pin_bidir_sel(pin_bidir_sel), .throttle_in(throttle_in), .throttle_out(throttle_out),
		.throttle_oe(throttle_oe), .guard_irq(guard_irq));
	far_side_model i_far (.aclk(aclk), .aresetn(aresetn), .sample_cmd(smp), .pwm_en(pwm_en),
		.duty_cmd(duty_cmd), .throttle_oe(throttle_oe), .supply_sense_in(sense),
		.supply_sense_valid(sense_v), .force_throttle_n(force_n), .duty_limit_flag(duty),
		.throttle_in(throttle_in));
	function automatic logic exp_oe(logic bd, logic fn, logic dl, logic ov);
		return bd & (!fn | dl | !ov);
	endfunction
	function automatic logic [31:0] inst_bits(int g, logic [3:0] v);
		return 32'(v) << (guard_pkg::IRQ_INST_BASE + g * guard_pkg::IRQ_PER_INST);
	endfunction
	// a sample strictly between the references used below
	function automatic logic [9:0] mid_smp();
		return {8'h11 + 8'($urandom % 8'hAF), 2'($urandom)};
	endfunction
	task automatic axw(input logic [7:0] a, input logic [31:0] v);
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!(bvalid && bready));
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic axr(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!(rvalid && rready));
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
		axr(a);
		`CHK(r, guard_pkg::RESP_OKAY, "read refused")
		`CHK(d & m, x, "register value")
	endtask
	task automatic conclude();
		if (n_fail == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#1000000;
		n_fail++;
		conclude();
	end
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, pwm_en, duty_cmd, pin_bidir_sel} = '0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hF;
		override_in = 1'b1;
		smp = '0;
		void'($urandom(27));
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rchk(8'h00, 32'h0000_00FF, guard_pkg::CTRL_RST);
		rchk(8'h20, 32'h0000_00FF, guard_pkg::CTRL_RST);
		rchk(8'h08, 32'h0000_FFFF, guard_pkg::REF_RST);
		rchk(8'h44, 32'h0000_01FF, 32'h0);
		axr(8'h18);
		`CHK(r, guard_pkg::RESP_SLVERR, "unmapped read")
		axw(8'h18, 32'hFFFF_FFFF);
		`CHK(r, guard_pkg::RESP_SLVERR, "unmapped write")
		// random pull sources with both instances disabled
		repeat (300) begin
			@(posedge aclk);
			e = exp_oe(pin_bidir_sel, force_n, duty, override_in);
			pin_bidir_sel <= 1'($urandom);
			override_in <= ($urandom % 4) != 0;
			pwm_en <= 1'($urandom);
			duty_cmd <= ($urandom % 4) == 0;
			#1 `CHK(throttle_oe, e, "throttle enable")
		end
		pwm_en <= 1'b0;
		duty_cmd <= 1'b0;
		override_in <= 1'b1;
		pin_bidir_sel <= 1'b1;
		axw(8'h40, 32'hFFFF_FFFF);
		axw(8'h44, 32'h0000_0001);
		`CHK(r, guard_pkg::RESP_OKAY, "write refused")
		`CHK(guard_irq, 1'b0, "irq with no status")
		pwm_en <= 1'b1;
		repeat (8) @(posedge aclk);
		pwm_en <= 1'b0;
		rchk(8'h40, 32'h1, 32'h1);
		`CHK(guard_irq, 1'b1, "force irq")
		axw(8'h40, 32'h1);
		rchk(8'h40, 32'h1, 32'h0);
		`CHK(guard_irq, 1'b0, "irq after clear")
		axw(8'h44, 32'h0000_01FE);
		for (int g = 0; g < 2; g++) begin
			b = 8'(g * 32);
			s = mid_smp();
			smp[g] <= s;
			smp[1 - g] <= ~s;
			axw(b + 8'h08, 32'h0000_C010);
			axw(b, 32'h0);
			repeat (6) @(posedge aclk);
			rchk(b + 8'h04, 32'h0000_FF00, {16'h0, s[9:2], 8'h0});
			`CHK(throttle_oe, 1'b0, "no compare in range")
			smp[g] <= {8'hC0, 2'b11};
			repeat (6) @(posedge aclk);
			rchk(b, 32'h0000_0300, 32'h0000_0100);
			`CHK(throttle_oe, 1'b1, "high compare pulls")
			smp[g] <= {8'h10, 2'b00};
			repeat (6) @(posedge aclk);
			rchk(b, 32'h0000_0300, 32'h0000_0200);
			smp[g] <= mid_smp();
			repeat (6) @(posedge aclk);
			rchk(8'h40, inst_bits(g, 4'hF), inst_bits(g, 4'hF));
			`CHK(guard_irq, 1'b1, "compare irq")
			// window 4 filters settle on a steady input; long high delay holds the compare back
			axw(b + 8'h10, 32'h0100_0000);
			axw(b + 8'h14, 32'h0100_0000);
			axw(b + 8'h0C, 32'h0000_00FF);
			smp[g] <= {8'hC0, 2'b01};
			axw(b, 32'h8);
			repeat (200) @(posedge aclk);
			rchk(b + 8'h04, 32'hFFFF_FF00, 32'hC0C0_C000);
			rchk(b, 32'h0000_0300, 32'h0);
			repeat (200) @(posedge aclk);
			rchk(b, 32'h0000_0300, 32'h0000_0100);
			s = mid_smp();
			axw(b + 8'h04, {24'h0, s[9:2]});
			axw(b, 32'h2);
			repeat (6) @(posedge aclk);
			rchk(b + 8'h04, 32'h0000_FF00, {16'h0, s[9:2], 8'h0});
			axw(b, 32'h1);
			smp[g] <= {8'hC0, 2'b00};
			repeat (6) @(posedge aclk);
			rchk(b, 32'h0000_0300, 32'h0);
			axw(8'h40, 32'hFFFF_FFFF);
		end
		conclude();
	end
endmodule
bind supply_voltage_guard guard_checker i_chk (.aclk(aclk), .aresetn(aresetn),
	.awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp),
	.bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata),
	.rvalid(rvalid), .rready(rready), .force_throttle_n(force_throttle_n),
	.duty_limit_flag(duty_limit_flag), .override_in(override_in),
	.pin_bidir_sel(pin_bidir_sel), .throttle_out(throttle_out), .throttle_oe(throttle_oe),
	.guard_irq(guard_irq));
